// File: serial_ata_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
module serial_ata_drive_model
    import serial_ata_sharing_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic xfer,
    input wire logic done,
    input wire logic [1:0] link_rate,
    output logic [7:0] words_r,
    output logic done_seen_r
);
    // Words land only while the link runs
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            words_r <= 8'h00;
            done_seen_r <= 1'b0;
        end
        else
        begin
            if (xfer && link_rate == RATE_MAX)
                words_r <= words_r + 8'h01;
            if (done)
                done_seen_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: serial_ata_function_sharing.sv
// Summary of operation
// - Native mode presents serial and parallel ATA as two separate functions.
// - Combined mode presents one function serving both serial and parallel ports.
// - Mapping register enables sharing; then serial function decodes all drive I/O.
// - Hide bit 1 at F2h removes parallel function 31/1 and its registers.
// - Capability pointer at 34h skips MSI while in combined mode.
// - Two serial ports, each enabled or disabled independently.
// - Each port has its own independent DMA engine.
// - Drive register access behaves like a classic task-file register set.
// - Link rate does not depend on any Ultra DMA setting.
// - Each enabled port runs its link at maximum speed.
`timescale 1ns/1ns
`default_nettype none
module serial_ata_function_sharing
    import serial_ata_sharing_pkg::*;
#(
    parameter int PORTS = 2,
    parameter int LEN_W = 7
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire cfg_req_t cfg_req,
    output logic cfg_ack_r,
    output logic cfg_unclaimed_r,
    output logic [31:0] cfg_rdata_r,
    input wire io_req_t io_req,
    output logic io_claim_serial_r,
    output logic io_claim_parallel_r,
    output logic io_port_sel_r,
    output logic [3:0] io_reg_sel_r,
    output logic combined_r,
    output logic parallel_visible_r,
    output logic [PORTS-1:0][1:0] link_rate_r,
    output logic [PORTS-1:0] dma_busy_r,
    output logic [PORTS-1:0] dma_done_r,
    output logic [PORTS-1:0] dma_xfer_r
);
    logic [15:0] hide_r;
    logic [7:0] map_r;
    logic [PORTS-1:0] port_en_r;
    logic [7:0] udma_serial_r;
    logic [7:0] udma_parallel_r;
    logic [PORTS-1:0] dma_start_r;
    logic [PORTS-1:0][LEN_W-1:0] dma_len_r;
    logic [PORTS-1:0] eng_busy;
    logic [PORTS-1:0] eng_done;
    logic [PORTS-1:0] eng_xfer;
    logic wr_ok;
    logic rd_ok;
    logic combined;
    logic hidden;
    logic [2:0] io_win;

    function automatic logic hit(input cfg_req_t r, input logic [2:0] f, input logic [5:0] d);
        hit = r.valid && r.func == f && r.dw == d;
    endfunction

    function automatic logic [2:0] io_window(input logic [15:0] a);
        if (a[15:3] == IO_PRI_BASE[15:3])
            io_window = {1'b1, 2'h0};
        else if (a[15:3] == IO_SEC_BASE[15:3])
            io_window = {1'b1, 2'h1};
        else
            io_window = 3'h0;
    endfunction

    assign combined = map_r[MAP_COMBINED_BIT];
    assign hidden = hide_r[HIDE_PARALLEL_BIT];
    assign wr_ok = cfg_req.valid && cfg_req.wr;
    assign rd_ok = cfg_req.valid && !cfg_req.wr;
    assign io_win = io_window(io_req.addr);

    always_ff @(posedge core_clk)
    begin
        if (reset)
            hide_r <= HIDE_RST;
        else if (wr_ok && hit(cfg_req, FN_BRIDGE, HIDE_DW))
        begin
            if (cfg_req.be[2])
                hide_r[7:0] <= cfg_req.data[23:16];
            if (cfg_req.be[3])
                hide_r[15:8] <= cfg_req.data[31:24];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            map_r <= MAP_RST;
            port_en_r <= PORT_EN_RST;
        end
        else if (wr_ok && hit(cfg_req, FN_SERIAL, MAP_DW))
        begin
            if (cfg_req.be[0])
                map_r <= cfg_req.data[7:0];
            if (cfg_req.be[2])
                port_en_r <= cfg_req.data[16 +: PORTS];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            udma_serial_r <= UDMA_RST;
            udma_parallel_r <= UDMA_RST;
        end
        else
        begin
            if (wr_ok && hit(cfg_req, FN_SERIAL, UDMA_DW) && cfg_req.be[0])
                udma_serial_r <= cfg_req.data[7:0];
            if (wr_ok && !hidden && hit(cfg_req, FN_PARALLEL, UDMA_DW) && cfg_req.be[0])
                udma_parallel_r <= cfg_req.data[7:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            dma_start_r <= '0;
            dma_len_r <= '0;
        end
        else
        begin
            for (int i = 0; i < PORTS; i++)
            begin
                dma_start_r[i] <= wr_ok && hit(cfg_req, FN_SERIAL, DMA_DW) && cfg_req.be[i]
                    && cfg_req.data[8*i];
                if (wr_ok && hit(cfg_req, FN_SERIAL, DMA_DW) && cfg_req.be[i])
                    dma_len_r[i] <= cfg_req.data[8*i+1 +: LEN_W];
            end
        end
    end

    generate
        for (genvar g = 0; g < PORTS; g++)
        begin : g_port
            serial_ata_port_engine #(.LEN_W(LEN_W)) u_engine (
                .core_clk(core_clk),
                .reset(reset),
                .enable(port_en_r[g]),
                .start(dma_start_r[g]),
                .len(dma_len_r[g]),
                .busy_r(eng_busy[g]),
                .done_r(eng_done[g]),
                .xfer_r(eng_xfer[g])
            );
        end
    endgenerate

    always_comb
    begin
        dma_busy_r = eng_busy;
        dma_done_r = eng_done;
        dma_xfer_r = eng_xfer;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg_ack_r <= 1'b0;
            cfg_unclaimed_r <= 1'b0;
            cfg_rdata_r <= '0;
        end
        else
        begin
            cfg_ack_r <= cfg_req.valid;
            cfg_unclaimed_r <= cfg_req.valid && cfg_req.func == FN_PARALLEL && hidden;
            cfg_rdata_r <= '0;
            if (rd_ok)
            begin
                case (cfg_req.func)
                    FN_BRIDGE:
                        if (cfg_req.dw == HIDE_DW)
                            cfg_rdata_r <= {hide_r, 16'h0000};
                    FN_PARALLEL:
                        if (hidden)
                            cfg_rdata_r <= CFG_NONE;
                        else if (cfg_req.dw == UDMA_DW)
                            cfg_rdata_r <= {24'h000000, udma_parallel_r};
                    FN_SERIAL:
                        if (cfg_req.dw == CAP_PTR_DW)
                            cfg_rdata_r <= {24'h000000, combined ? CAP_PM : CAP_MSI};
                        else if (cfg_req.dw == UDMA_DW)
                            cfg_rdata_r <= {24'h000000, udma_serial_r};
                        else if (cfg_req.dw == MAP_DW)
                            cfg_rdata_r <= {8'h00, 8'(port_en_r), 8'h00, map_r};
                        else if (cfg_req.dw == DMA_DW)
                            cfg_rdata_r <= {16'h0000, 7'h00, eng_busy[1], 7'h00, eng_busy[0]};
                    default:
                        cfg_rdata_r <= CFG_NONE;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            io_claim_serial_r <= 1'b0;
            io_claim_parallel_r <= 1'b0;
            io_port_sel_r <= 1'b0;
            io_reg_sel_r <= 4'h0;
        end
        else
        begin
            io_claim_serial_r <= io_req.valid && io_win[2] && combined;
            io_claim_parallel_r <= io_req.valid && io_win[2] && !combined && !hidden;
            io_port_sel_r <= io_win[0];
            io_reg_sel_r <= {1'b0, io_req.addr[2:0]};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < PORTS; i++)
                link_rate_r[i] <= PORT_EN_RST[i] ? RATE_MAX : RATE_OFF;
            combined_r <= 1'b0;
            parallel_visible_r <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < PORTS; i++)
                link_rate_r[i] <= port_en_r[i] ? RATE_MAX : RATE_OFF;
            combined_r <= combined;
            parallel_visible_r <= !hidden;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence seq_par_read;
        cfg_req.valid && !cfg_req.wr && cfg_req.func == FN_PARALLEL;
    endsequence

    sequence seq_cap_read;
        rd_ok && cfg_req.func == FN_SERIAL && cfg_req.dw == CAP_PTR_DW;
    endsequence

    sequence seq_legacy_io;
        io_req.valid && io_win[2];
    endsequence

    AST_HIDE_UNCLAIMED: assert property (seq_par_read and hidden |=> cfg_ack_r && cfg_unclaimed_r)
        else $error("hidden parallel function answered");
    AST_PARALLEL_VISIBLE: assert property (seq_par_read and !hidden |=> cfg_ack_r && !cfg_unclaimed_r)
        else $error("visible parallel function unclaimed");
    AST_NATIVE_TWO: assert property (rd_ok && !combined && !hidden && cfg_req.func == FN_PARALLEL
        ##1 rd_ok && cfg_req.func == FN_SERIAL |=> !cfg_unclaimed_r && $past(!cfg_unclaimed_r))
        else $error("native mode lost a function");
    AST_COMBINED_ONE: assert property (seq_legacy_io and combined |=> !io_claim_parallel_r)
        else $error("parallel function claimed in combined mode");
    AST_SHARE_DECODE: assert property (seq_legacy_io and combined |=> io_claim_serial_r)
        else $error("serial function missed shared decode");
    AST_CAP_PTR: assert property (seq_cap_read |=> cfg_rdata_r[7:0] == (combined_r ? CAP_PM : CAP_MSI))
        else $error("capability pointer wrong for mode");
    AST_PORT_INDEP: assert property ($stable(port_en_r[1]) ##1 1'b1 |-> $stable(link_rate_r[1]))
        else $error("port 1 link changed without its enable");
    AST_DMA_INDEP: assert property (dma_start_r[0] && eng_busy[1] && port_en_r[1] |=> eng_busy[1]
        || eng_done[1])
        else $error("port 0 start disturbed port 1 engine");
    AST_TASKFILE: assert property (seq_legacy_io |=> io_reg_sel_r[2:0] == $past(io_req.addr[2:0]))
        else $error("task-file register select wrong");
    AST_UDMA_FREE: assert property ($changed(udma_serial_r) && $stable(port_en_r) |=> $stable(link_rate_r))
        else $error("link rate followed udma setting");
    AST_LINK_MAX: assert property (port_en_r[0] ##1 port_en_r[0] |-> link_rate_r[0] == RATE_MAX)
        else $error("enabled port not at maximum rate");
endmodule
`default_nettype wire

// File: serial_ata_function_sharing_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module serial_ata_function_sharing_tb;
    import serial_ata_sharing_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    cfg_req_t cfg_req = '0;
    io_req_t io_req = '0;
    logic cfg_ack_r, cfg_unclaimed_r, io_claim_serial_r, io_claim_parallel_r, io_port_sel_r;
    logic combined_r, parallel_visible_r;
    logic [31:0] cfg_rdata_r, rd;
    logic [3:0] io_reg_sel_r;
    logic [1:0][1:0] link_rate_r;
    logic [1:0] dma_busy_r, dma_done_r, dma_xfer_r, done_seen;
    logic [1:0][7:0] words;
    logic [15:0] addr;
    logic [6:0] len0, len1;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 32'h4cd4;
    int i;

    always #4 core_clk = ~core_clk;

    serial_ata_function_sharing u_serial_ata_function_sharing (.core_clk(core_clk), .reset(reset), .cfg_req(cfg_req),
        .cfg_ack_r(cfg_ack_r), .cfg_unclaimed_r(cfg_unclaimed_r), .cfg_rdata_r(cfg_rdata_r), .io_req(io_req),
        .io_claim_serial_r(io_claim_serial_r), .io_claim_parallel_r(io_claim_parallel_r),
        .io_port_sel_r(io_port_sel_r), .io_reg_sel_r(io_reg_sel_r), .combined_r(combined_r),
        .parallel_visible_r(parallel_visible_r), .link_rate_r(link_rate_r), .dma_busy_r(dma_busy_r),
        .dma_done_r(dma_done_r), .dma_xfer_r(dma_xfer_r));

    for (genvar g = 0; g < 2; g++)
    begin : g_drv
        serial_ata_drive_model u_serial_ata_drive_model (.core_clk(core_clk), .reset(reset), .xfer(dma_xfer_r[g]),
            .done(dma_done_r[g]), .link_rate(link_rate_r[g]), .words_r(words[g]), .done_seen_r(done_seen[g]));
    end

    function automatic logic legacy(input logic [15:0] a);
        return (a[15:3] == IO_PRI_BASE[15:3]) || (a[15:3] == IO_SEC_BASE[15:3]);
    endfunction

    task automatic cfg(input logic wr, input logic [2:0] func, input logic [5:0] dw, input logic [3:0] be,
        input logic [31:0] data);
        @(posedge core_clk);
        cfg_req <= '{1'b1, wr, func, dw, be, data};
        @(posedge core_clk);
        cfg_req.valid <= 1'b0;
        #1;
        `CHK(cfg_ack_r, 1'b1)
        rd = cfg_rdata_r;
    endtask

    task automatic cfg_pair(input logic [2:0] f0, input logic [5:0] d0, input logic [2:0] f1,
        input logic [5:0] d1);
        @(posedge core_clk);
        cfg_req <= '{1'b1, 1'b0, f0, d0, 4'hF, 32'h0};
        @(posedge core_clk);
        cfg_req <= '{1'b1, 1'b0, f1, d1, 4'hF, 32'h0};
        #1;
        `CHK(cfg_ack_r, 1'b1)
        `CHK(cfg_unclaimed_r, 1'b0)
        @(posedge core_clk);
        cfg_req.valid <= 1'b0;
        #1;
        `CHK(cfg_ack_r, 1'b1)
        `CHK(cfg_unclaimed_r, 1'b0)
        rd = cfg_rdata_r;
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic io_check(input logic comb, input logic vis);
        for (i = 0; i < 12; i++)
        begin
            addr = 16'($random(seed));
            if (i < 8)
                addr = {(i[0] ? IO_SEC_BASE[15:3] : IO_PRI_BASE[15:3]), addr[2:0]};
            if (i == 8)
                addr = 16'h01F8;
            if (i == 9)
                addr = 16'h016F;
            @(posedge core_clk);
            io_req <= '{1'b1, addr};
            @(posedge core_clk);
            io_req.valid <= 1'b0;
            #1;
            `CHK(io_claim_serial_r, legacy(addr) && comb)
            `CHK(io_claim_parallel_r, legacy(addr) && !comb && vis)
            if (legacy(addr))
            begin
                `CHK(io_reg_sel_r, {1'b0, addr[2:0]})
                `CHK(io_port_sel_r, (addr[15:3] == IO_SEC_BASE[15:3]))
            end
        end
    endtask

    task automatic summarize();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        `CHK(combined_r, 1'b0)
        `CHK(parallel_visible_r, 1'b1)
        `CHK(link_rate_r[0], RATE_MAX)
        `CHK(link_rate_r[1], RATE_MAX)
        cfg(1'b1, FN_SERIAL, CAP_PTR_DW, 4'hF, 32'h0000005A);
        cfg(1'b0, FN_SERIAL, CAP_PTR_DW, 4'hF, 32'h0);
        `CHK(rd[7:0], CAP_MSI)
        cfg(1'b0, FN_PARALLEL, 6'h00, 4'hF, 32'h0);
        `CHK(cfg_unclaimed_r, 1'b0)
        `CHK(rd === CFG_NONE, 1'b0)
        cfg_pair(FN_PARALLEL, UDMA_DW, FN_SERIAL, CAP_PTR_DW);
        `CHK(rd[7:0], CAP_MSI)
        io_check(1'b0, 1'b1);
        cfg(1'b1, FN_SERIAL, UDMA_DW, 4'h1, $random(seed));
        cfg(1'b1, FN_PARALLEL, UDMA_DW, 4'h1, $random(seed));
        settle();
        `CHK(link_rate_r, {RATE_MAX, RATE_MAX})
        cfg(1'b1, FN_SERIAL, MAP_DW, 4'h1, 32'h00000001);
        settle();
        `CHK(combined_r, 1'b1)
        cfg(1'b0, FN_SERIAL, CAP_PTR_DW, 4'hF, 32'h0);
        `CHK(rd[7:0], CAP_PM)
        io_check(1'b1, 1'b1);
        cfg(1'b1, FN_BRIDGE, HIDE_DW, 4'hC, 32'h00020000);
        settle();
        `CHK(parallel_visible_r, 1'b0)
        cfg(1'b0, FN_PARALLEL, 6'h00, 4'hF, 32'h0);
        `CHK(cfg_unclaimed_r, 1'b1)
        `CHK(rd, CFG_NONE)
        cfg(1'b1, FN_SERIAL, MAP_DW, 4'h1, 32'h0);
        settle();
        io_check(1'b0, 1'b0);
        cfg(1'b1, FN_SERIAL, MAP_DW, 4'h4, 32'h00010000);
        settle();
        `CHK(link_rate_r[1], RATE_OFF)
        `CHK(link_rate_r[0], RATE_MAX)
        cfg(1'b1, FN_SERIAL, MAP_DW, 4'h4, 32'h00030000);
        settle();
        `CHK(link_rate_r[1], RATE_MAX)
        len0 = 7'd3 + 7'($random(seed) & 7);
        len1 = 7'd12 + 7'($random(seed) & 7);
        cfg(1'b1, FN_SERIAL, DMA_DW, 4'h2, {16'h0000, len1, 1'b1, 8'h00});
        cfg(1'b1, FN_SERIAL, DMA_DW, 4'h1, {16'h0000, 8'h00, len0, 1'b1});
        `CHK(dma_busy_r[1], 1'b1)
        for (i = 0; i < 400 && done_seen !== 2'b11; i++)
            @(posedge core_clk);
        #1;
        `CHK(dma_busy_r, 2'b00)
        `CHK(words[0], {1'b0, len0})
        `CHK(words[1], {1'b0, len1})
        summarize();
    end
endmodule
`default_nettype wire

// File: serial_ata_port_engine.sv
`timescale 1ns/1ns
`default_nettype none
module serial_ata_port_engine
    import serial_ata_sharing_pkg::*;
#(
    parameter int LEN_W = 7
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic start,
    input wire logic [LEN_W-1:0] len,
    output logic busy_r,
    output logic done_r,
    output logic xfer_r
);
    logic [LEN_W-1:0] count_r;

    // Word counter
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busy_r <= 1'b0;
            count_r <= '0;
        end
        else if (!enable)
        begin
            busy_r <= 1'b0;
            count_r <= '0;
        end
        else if (!busy_r && start && len != '0)
        begin
            busy_r <= 1'b1;
            count_r <= len;
        end
        else if (busy_r)
        begin
            count_r <= count_r - 1'b1;
            busy_r <= (count_r != {{(LEN_W-1){1'b0}}, 1'b1});
        end
    end

    // Strobes
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            done_r <= 1'b0;
            xfer_r <= 1'b0;
        end
        else
        begin
            xfer_r <= busy_r && enable;
            done_r <= busy_r && enable && count_r == {{(LEN_W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// File: serial_ata_sharing_pkg.sv
package serial_ata_sharing_pkg;

    // Device and function numbers of the hub
    localparam logic [4:0] HUB_DEV_NUM = 5'h1F;
    localparam logic [2:0] FN_BRIDGE = 3'h0;
    localparam logic [2:0] FN_PARALLEL = 3'h1;
    localparam logic [2:0] FN_SERIAL = 3'h2;

    // Dword indices of configuration registers
    localparam logic [5:0] CAP_PTR_DW = 6'h0D;
    localparam logic [5:0] HIDE_DW = 6'h3C;
    localparam logic [5:0] UDMA_DW = 6'h12;
    localparam logic [5:0] MAP_DW = 6'h24;
    localparam logic [5:0] DMA_DW = 6'h25;

    // Byte offsets within the space
    localparam logic [7:0] CAP_PTR_OFF = 8'h34;
    localparam logic [7:0] HIDE_OFF = 8'hF2;
    localparam logic [7:0] UDMA_OFF = 8'h48;
    localparam logic [7:0] MAP_OFF = 8'h90;
    localparam logic [7:0] PORT_EN_OFF = 8'h92;
    localparam logic [7:0] DMA_OFF = 8'h94;

    // Field positions
    localparam int HIDE_PARALLEL_BIT = 1;
    localparam int MAP_COMBINED_BIT = 0;

    // Capability pointer values
    localparam logic [7:0] CAP_MSI = 8'h80;
    localparam logic [7:0] CAP_PM = 8'h70;

    // Reset values
    localparam logic [15:0] HIDE_RST = 16'h0000;
    localparam logic [7:0] MAP_RST = 8'h00;
    localparam logic [1:0] PORT_EN_RST = 2'h3;
    localparam logic [7:0] UDMA_RST = 8'h00;

    // Link rates
    localparam logic [1:0] RATE_OFF = 2'h0;
    localparam logic [1:0] RATE_MAX = 2'h1;

    // Legacy task-file I/O windows and the unclaimed read value
    localparam logic [15:0] IO_PRI_BASE = 16'h01F0;
    localparam logic [15:0] IO_SEC_BASE = 16'h0170;
    localparam logic [31:0] CFG_NONE = 32'hFFFFFFFF;

    typedef struct packed {
        logic valid;
        logic wr;
        logic [2:0] func;
        logic [5:0] dw;
        logic [3:0] be;
        logic [31:0] data;
    } cfg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } io_req_t;

endpackage
